// [src/citd_decoder.v]
// Opcode length and cycle count decoder with fetch hold sequencing
//
// What this block does
// - Count every instruction in plain system clocks
// - Most instructions take cycles equal bytes
// - Untaken conditional branch is one clock shorter
// - External data write is the flash write path
// - No off-chip data or program memory port
// - Add family: reg 1/1, direct 2/2, indirect 1/2
// - Inc/dec 1 or 2; multiply 4; divide 8
// - Logic ops as add; direct forms 2/2, 3/3
// - Accumulator-only operations take one byte, one cycle
// - Direct-direct, immediate-direct, pointer load take 3/3
// - Indirect RAM moves take two cycles
// - Both code byte reads take 1/3
// - All external data moves take 1/3
// - Stack push and pop take 2/2
// - Exchange register 1/1, direct 2/2
// - Standard encoding; only timing differs
// - Spare opcode behaves as no-operation
// - No instruction exceeds eight clocks
`timescale 1ns/10ps
`include "citd_consts.vh"

module citd_decoder #(
    parameter OPW = `CITD_OP_WIDTH,
    parameter CNTW = `CITD_CNT_WIDTH
) (
    input wire clk,
    input wire rst,
    input wire opValid,
    input wire [OPW-1:0] opcode,
    input wire branchTaken,
    output reg opReady,
    output reg [1:0] instLen,
    output reg [CNTW-1:0] instCycles,
    output reg instStart,
    output reg instDone,
    output reg isBranch,
    output reg flashWrite,
    output reg dataRead,
    output reg codeRead
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    reg [1:0] lenDec;
    reg [CNTW-1:0] cycDec;
    reg brDec;
    reg xwrDec;
    reg xrdDec;
    reg crdDec;
    wire [3:0] lo;
    wire [3:0] hi;

    assign lo = opcode[3:0];
    assign hi = opcode[7:4];

    always @* begin
        lenDec = 2'h1;
        cycDec = 4'h1;
        brDec = 1'b0;
        xwrDec = 1'b0;
        xrdDec = 1'b0;
        crdDec = 1'b0;
        // Columns 8..F are register forms: one byte, one cycle except rows 7, 8, A, B and D
        if (lo >= 4'h8) begin
            case (hi)
                4'h8, 4'hA: begin
                    lenDec = 2'h2;
                    cycDec = 4'h2;
                end
                4'hB: begin
                    // Compare immediate to register and jump
                    lenDec = 2'h3;
                    cycDec = 4'h4;
                    brDec = 1'b1;
                end
                4'hD: begin
                    lenDec = 2'h2;
                    cycDec = 4'h3;
                    brDec = 1'b1;
                end
                4'h7: begin
                    lenDec = 2'h2;
                    cycDec = 4'h2;
                end
                default: begin
                    lenDec = 2'h1;
                    cycDec = 4'h1;
                end
            endcase
        end else if (lo == 4'h6 || lo == 4'h7) begin
            // Indirect RAM forms take an extra cycle except rows 7, 8 and A, which match their register forms at two cycles, and row D at two against three
            case (hi)
                4'h7, 4'h8, 4'hA: begin
                    lenDec = 2'h2;
                    cycDec = 4'h2;
                end
                4'hB: begin
                    lenDec = 2'h3;
                    cycDec = 4'h5;
                    brDec = 1'b1;
                end
                default: begin
                    lenDec = 2'h1;
                    cycDec = 4'h2;
                end
            endcase
        end else if (lo == 4'h5) begin
            case (hi)
                4'h7, 4'h8: begin
                    lenDec = 2'h3;
                    cycDec = 4'h3;
                end
                4'hA: begin
                    lenDec = 2'h1;
                    cycDec = 4'h1;
                end
                4'hB, 4'hD: begin
                    lenDec = 2'h3;
                    cycDec = 4'h4;
                    brDec = 1'b1;
                end
                default: begin
                    lenDec = 2'h2;
                    cycDec = 4'h2;
                end
            endcase
        end else if (lo == 4'h4) begin
            case (hi)
                4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hB: begin
                    lenDec = (hi == 4'hB) ? 2'h3 : 2'h2;
                    cycDec = (hi == 4'hB) ? 4'h4 : 4'h2;
                    brDec = (hi == 4'hB);
                end
                4'h8: begin
                    cycDec = `CITD_CYC_DIV;
                end
                4'hA: begin
                    cycDec = `CITD_CYC_MUL;
                end
                default: begin
                    lenDec = 2'h1;
                    cycDec = 4'h1;
                end
            endcase
        end else if (lo == 4'h3) begin
            case (hi)
                4'h0, 4'h1, 4'h2, 4'h3, 4'hA, 4'hB, 4'hC, 4'hD: begin
                    lenDec = 2'h1;
                    cycDec = 4'h1;
                end
                4'h4, 4'h5, 4'h6: begin
                    lenDec = 2'h3;
                    cycDec = 4'h3;
                end
                4'h8, 4'h9: begin
                    cycDec = `CITD_CYC_CODE;
                    crdDec = 1'b1;
                end
                4'h7: begin
                    lenDec = 2'h1;
                    cycDec = 4'h3;
                end
                default: begin
                    xrdDec = (hi == 4'hE);
                    xwrDec = (hi == 4'hF);
                    cycDec = `CITD_CYC_XDATA;
                end
            endcase
        end else if (lo == 4'h2) begin
            case (hi)
                4'h0, 4'h1: begin
                    lenDec = 2'h3;
                    cycDec = 4'h4;
                end
                4'h2, 4'h3: cycDec = 4'h5;
                4'h4, 4'h5, 4'h6: begin
                    lenDec = 2'h2;
                    cycDec = 4'h2;
                end
                4'hE, 4'hF: begin
                    xrdDec = (hi == 4'hE);
                    xwrDec = (hi == 4'hF);
                    cycDec = `CITD_CYC_XDATA;
                end
                default: begin
                    lenDec = 2'h2;
                    cycDec = 4'h2;
                end
            endcase
        end else if (lo == 4'h1) begin
            // Absolute jump and call
            lenDec = 2'h2;
            cycDec = 4'h3;
        end else begin
            case (hi)
                4'h0: begin
                    lenDec = 2'h1;
                    cycDec = 4'h1;
                end
                4'h1, 4'h2, 4'h3: begin
                    lenDec = 2'h3;
                    cycDec = 4'h4;
                    brDec = 1'b1;
                end
                4'h4, 4'h5, 4'h6, 4'h7: begin
                    lenDec = 2'h2;
                    cycDec = 4'h3;
                    brDec = 1'b1;
                end
                4'h8: begin
                    lenDec = 2'h2;
                    cycDec = 4'h3;
                end
                4'h9: begin
                    lenDec = 2'h3;
                    cycDec = 4'h3;
                end
                4'hC, 4'hD: begin
                    lenDec = 2'h2;
                    cycDec = 4'h2;
                end
                4'hE, 4'hF: begin
                    xrdDec = (hi == 4'hE);
                    xwrDec = (hi == 4'hF);
                    cycDec = `CITD_CYC_XDATA;
                end
                default: begin
                    lenDec = 2'h2;
                    cycDec = 4'h2;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_EXEC = 1'b1;

    reg state_r;
    reg [CNTW-1:0] remain_r;
    wire accept;

    assign accept = opValid && opReady;

    always @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            remain_r <= {CNTW{1'b0}};
            opReady <= 1'b1;
            instLen <= 2'h0;
            instCycles <= {CNTW{1'b0}};
            instStart <= 1'b0;
            instDone <= 1'b0;
            isBranch <= 1'b0;
            flashWrite <= 1'b0;
            dataRead <= 1'b0;
            codeRead <= 1'b0;
        end else begin
            instStart <= accept;
            instDone <= 1'b0;
            flashWrite <= 1'b0;
            dataRead <= 1'b0;
            codeRead <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (accept) begin
                        instLen <= lenDec;
                        instCycles <= cycDec;
                        isBranch <= brDec;
                        flashWrite <= xwrDec;
                        dataRead <= xrdDec;
                        codeRead <= crdDec;
                        // Untaken branch ends one clock early
                        if (brDec && !branchTaken) begin
                            remain_r <= cycDec - 4'h1;
                        end else begin
                            remain_r <= cycDec;
                        end
                        if (cycDec == 4'h1 ||
                            (brDec && !branchTaken && cycDec == 4'h2)) begin
                            instDone <= 1'b1;
                            opReady <= 1'b1;
                        end else begin
                            state_r <= ST_EXEC;
                            opReady <= 1'b0;
                        end
                    end
                end
                ST_EXEC: begin
                    remain_r <= remain_r - 4'h1;
                    if (remain_r == 4'h2) begin
                        instDone <= 1'b1;
                        opReady <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

endmodule

// [src/citd_consts.vh]
// Constants for the instruction decode and cycle timing block
`ifndef CITD_CONSTS_VH
`define CITD_CONSTS_VH
`define CITD_OP_WIDTH 8
`define CITD_CNT_WIDTH 4
`define CITD_MAX_CYCLES 4'h8
`define CITD_CYC_MUL 4'h4
`define CITD_CYC_DIV 4'h8
`define CITD_CYC_CODE 4'h3
`define CITD_CYC_XDATA 4'h3
`define CITD_OP_NOP 8'h00
`define CITD_OP_SPARE 8'hA5
`define CITD_OP_MUL 8'hA4
`define CITD_OP_DIV 8'h84
`define CITD_OP_CODE_DP 8'h93
`define CITD_OP_CODE_PC 8'h83
`define CITD_OP_XRD_RI0 8'hE2
`define CITD_OP_XRD_RI1 8'hE3
`define CITD_OP_XRD_DP 8'hE0
`define CITD_OP_XWR_RI0 8'hF2
`define CITD_OP_XWR_RI1 8'hF3
`define CITD_OP_XWR_DP 8'hF0
`endif

// [tb/citd_decoder_props.sv]
// Timing checker for the instruction decoder ports
`timescale 1ns/10ps
`include "citd_consts.vh"
module citd_decoder_props #(
    parameter OPW = 8,
    parameter CNTW = 4
) (
    input logic clk,
    input logic rst,
    input logic opValid,
    input logic [OPW-1:0] opcode,
    input logic branchTaken,
    input logic opReady,
    input logic [1:0] instLen,
    input logic [CNTW-1:0] instCycles,
    input logic instStart,
    input logic instDone,
    input logic isBranch,
    input logic flashWrite,
    input logic dataRead,
    input logic codeRead
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
wire takeOp = opValid && opReady;
// Hold of the next fetch for two, three and four clock instructions
sequence hold2; !opReady ##1 opReady; endsequence
sequence hold3; !opReady[*2] ##1 opReady; endsequence
sequence hold4; !opReady[*3] ##1 opReady; endsequence
start_after_take_a: assert property (takeOp |=> instStart)
    else $error("no start after accept");
no_stray_start_a: assert property (!takeOp |=> !instStart)
    else $error("start without accept");
cycle_limit_a: assert property (instStart |-> instCycles != 0
    && instCycles <= `CITD_MAX_CYCLES) else $error("cycle count range");
mul_timing_a: assert property (takeOp && opcode == `CITD_OP_MUL
    |=> instCycles == `CITD_CYC_MUL ##0 hold4)
    else $error("multiply timing");
div_hold_a: assert property (takeOp && opcode == `CITD_OP_DIV
    |=> !opReady[*7] ##1 opReady) else $error("divide timing");
branch_taken_a: assert property (takeOp && opcode == 8'h60
    && branchTaken |=> hold3) else $error("taken branch timing");
branch_skip_a: assert property (takeOp && opcode == 8'h60
    && !branchTaken |=> hold2) else $error("untaken branch timing");
flash_path_a: assert property (takeOp && opcode inside
    {`CITD_OP_XWR_DP, `CITD_OP_XWR_RI0, `CITD_OP_XWR_RI1}
    |=> flashWrite && !dataRead) else $error("flash write strobe");
code_read_a: assert property (takeOp && opcode inside
    {`CITD_OP_CODE_DP, `CITD_OP_CODE_PC} |=> codeRead
    && instCycles == `CITD_CYC_CODE) else $error("code read");
spare_nop_a: assert property (takeOp && opcode == `CITD_OP_SPARE
    |=> instCycles == 4'h1 && opReady && !flashWrite)
    else $error("spare opcode");
endmodule

// [tb/citd_mem_model.sv]
// Far side model: on-chip flash and data memory access counter
`timescale 1ns/10ps
module citd_mem_model (
    input logic clk,
    input logic flashWrite,
    input logic dataRead,
    input logic codeRead,
    output int wrCount,
    output int rdCount,
    output int cdCount
);
initial begin
    wrCount = 0;
    rdCount = 0;
    cdCount = 0;
end
// Every access lands on chip memory
always @(posedge clk) begin
    wrCount <= wrCount + (flashWrite === 1'b1);
    rdCount <= rdCount + (dataRead === 1'b1);
    cdCount <= cdCount + (codeRead === 1'b1);
end
endmodule

// [tb/citd_decoder_tb.sv]
// Testbench for the instruction decode and cycle timing block
`timescale 1ns/10ps
`include "citd_consts.vh"
module citd_decoder_tb;
logic clk, rst, opValid, branchTaken, opReady, instStart, instDone;
logic isBranch, flashWrite, dataRead, codeRead;
logic [7:0] opcode;
logic [1:0] instLen;
logic [3:0] instCycles;
int n_fail = 0;
int check_count = 0;
int wrCount, rdCount, cdCount;
int expWr = 0, expRd = 0, expCd = 0;
// Rows: opcode, branch and taken, bytes, listed cycles, effective cycles
logic [23:0] rows [$] = '{24'h280111, 24'h250222, 24'h360122,
    24'h940222, 24'h050222, 24'h170122, 24'hA30111, 24'hD40111,
    24'hA40144, 24'h840188, 24'h520222, 24'h430333, 24'h660122,
    24'hE40111, 24'hC40111, 24'h330111, 24'h850333, 24'h750333,
    24'h900333, 24'hF60122, 24'hE70122, 24'h930133, 24'h830133,
    24'hE00133, 24'hE20133, 24'hF00133, 24'hF30133, 24'hC00222,
    24'hD00222, 24'hCA0111, 24'hC50222, 24'h000111, 24'hA50111,
    24'h603233, 24'h602232, 24'h403233, 24'hD83233,
    24'hB62354, 24'h103344, 24'hB52343, 24'h440222,
    24'hB30111, 24'h120344, 24'hA00222};
citd_decoder u_dut (.clk, .rst, .opValid, .opcode, .branchTaken, .opReady,
    .instLen, .instCycles, .instStart, .instDone, .isBranch, .flashWrite,
    .dataRead, .codeRead);
citd_mem_model u_mem (.clk, .flashWrite, .dataRead, .codeRead, .wrCount,
    .rdCount, .cdCount);
initial begin
    clk = 0;
    forever #4 clk = ~clk;
end
task check_val(input string name, input logic [3:0] exp, got);
    check_count++;
    if (got !== exp) begin
        n_fail++;
        $display("Error %s expected %0h seen %0h", name, exp, got);
    end
endtask
task check_cnt(input string name, input int exp, got);
    check_count++;
    if (got != exp) begin
        n_fail++;
        $display("Error %s expected %0d seen %0d", name, exp, got);
    end
endtask
task report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
        $display("Regression OK");
    end else begin
        $display("Regression broken");
    end
    $finish;
endtask
task run_op(input logic [23:0] r);
    int n;
    int dones;
    @(posedge clk);
    #1 opValid = 1;
    opcode = r[23:16];
    branchTaken = r[12];
    @(posedge clk);
    #1 opValid = 0;
    check_val("instStart", 4'h1, {3'h0, instStart});
    check_val("instLen", {2'h0, r[9:8]}, {2'h0, instLen});
    check_val("instCycles", r[7:4], instCycles);
    check_val("isBranch", {3'h0, r[13]}, {3'h0, isBranch});
    n = 1;
    dones = (instDone === 1'b1);
    while (opReady !== 1'b1 && n < 20) begin
        @(posedge clk);
        #1 n++;
        dones += (instDone === 1'b1);
    end
    check_cnt("cycles", r[3:0], n);
    check_cnt("instDone", 1, dones);
endtask
initial begin
    rst = 1;
    opValid = 0;
    opcode = 8'h00;
    branchTaken = 0;
    repeat (3) @(posedge clk);
    #1 rst = 0;
    foreach (rows[i]) begin
        expWr += rows[i][23:16] inside {8'hF0, 8'hF2, 8'hF3};
        expRd += rows[i][23:16] inside {8'hE0, 8'hE2, 8'hE3};
        expCd += rows[i][23:16] inside {8'h93, 8'h83};
        run_op(rows[i]);
    end
    repeat (2) @(posedge clk);
    #1 check_cnt("flashWrite", expWr, wrCount);
    check_cnt("dataRead", expRd, rdCount);
    check_cnt("codeRead", expCd, cdCount);
    // Write offered while a multiply still holds the fetch
    opValid = 1;
    opcode = `CITD_OP_MUL;
    @(posedge clk);
    #1 opcode = `CITD_OP_XWR_DP;
    for (int i = 1; i <= 5; i++) begin
        if (i > 1) begin
            @(posedge clk);
            #1;
        end
        check_val("flashWrite", {3'h0, i == 5}, {3'h0, flashWrite});
    end
    opValid = 0;
    repeat (4) @(posedge clk);
    // Reset in the middle of a divide
    #1 opValid = 1;
    opcode = `CITD_OP_DIV;
    @(posedge clk);
    #1 opValid = 0;
    @(posedge clk);
    #1 rst = 1;
    @(posedge clk);
    #1 rst = 0;
    check_val("opReady", 4'h1, {3'h0, opReady});
    check_val("instStart", 4'h0, {3'h0, instStart});
    run_op(24'h280111);
    report_and_stop;
end
initial begin
    #100000 n_fail++;
    report_and_stop;
end
endmodule
bind citd_decoder citd_decoder_props #(.OPW(OPW), .CNTW(CNTW)) u_props (
    .clk, .rst, .opValid, .opcode, .branchTaken, .opReady, .instLen,
    .instCycles, .instStart, .instDone, .isBranch, .flashWrite, .dataRead,
    .codeRead);
